//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] TB = 32'h0000_0400;
  logic                  aclk, aresetn, slow, mem_ack;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [31:0]           awaddr, wdata, araddr, rdata, sreq, breq, mem_rdata, done, bad, rd, lf;
  logic [1:0]            bresp, rresp, rr, br;
  logic [3:0]            wstrb;
  udc_pkg::udc_mem_req_s mreq;
  int                    fails, check_count, i;

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  udc_dma udc_dma_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .dma_sreq(sreq), .dma_breq(breq), .mem_req(mreq),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dma_done(done));
  udc_mem_model #(.TBASE(TB)) udc_mem_model_inst (.aclk(aclk), .aresetn(aresetn),
    .slow(slow), .mem_req(mreq), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .bad_cnt(bad));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // word size and word increment on both sides
  function automatic logic [31:0] mk_ctl(input logic [2:0] m, input logic [9:0] n,
                                         input logic [3:0] arb);
    return {8'hAA, 6'h00, arb, n - 10'h001, 1'b0, m};
  endfunction
  function automatic logic [31:0] fin(input logic [31:0] c);
    return c & 32'hFFFF_C008;
  endfunction
  function automatic int cw(input int ch, input int alt);
    return (TB + alt * 32'h200 + ch * 16) / 4;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic hang(input string nm);
    fails++;
    $display("[FAIL] %s expected answer seen timeout", nm);
    print_verdict();
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    for (k = 0; k < 60; k++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        br     = bresp;
        bready <= 1'b0;
        return;
      end
    end
    hang("axi write");
  endtask
  task automatic axi_rd(input logic [31:0] a);
    int k;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (k = 0; k < 60; k++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
        return;
      end
    end
    hang("axi read");
  endtask
  task automatic wait_done(input int ch);
    int k;
    for (k = 0; k < 3000; k++)
    begin
      @(posedge aclk);
      if (done[ch] === 1'b1)
        return;
    end
    hang("done pulse");
  endtask
  task automatic setup(input int ch, input int alt, input logic [31:0] s,
                       input logic [31:0] d, input logic [31:0] c);
    udc_mem_model_inst.mem[cw(ch, alt)]     = s;
    udc_mem_model_inst.mem[cw(ch, alt) + 1] = d;
    udc_mem_model_inst.mem[cw(ch, alt) + 2] = c;
  endtask

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, slow} = 6'h00;
    {awaddr, wdata, araddr, sreq, breq} = 160'h0;
    wstrb   = 4'hF;
    aresetn = 1'b0;
    lf      = 32'h0000_0039;
    fails   = 0;
    check_count = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(32'h0000_0004);
    chk("enable reset", rd, 32'h0000_0000);
    axi_rd(32'h0000_0024);
    chk("unmapped resp", {30'h0, rr}, 32'h0000_0002);
    axi_wr(32'h0000_0000, TB);
    axi_rd(32'h0000_0000);
    chk("table base", rd, TB);
    chk("base wresp", {30'h0, br}, 32'h0000_0000);
    $display("test registers done");
    for (i = 0; i < 4; i++)
    begin
      lf = lfsr_next(lf);
      udc_mem_model_inst.mem[1024 + i] = lf;
      udc_mem_model_inst.mem[1536 + i] = 32'h0000_0000;
    end
    // four items in bursts of two, one software request
    setup(3, 0, 32'h0000_100C, 32'h0000_180C, mk_ctl(3'h2, 10'h004, 4'h1));
    axi_wr(32'h0000_0004, 32'h0000_0008);
    axi_wr(32'h0000_0020, 32'h0000_0008);
    wait_done(3);
    for (i = 0; i < 4; i++)
      chk("auto item", udc_mem_model_inst.mem[1536 + i], udc_mem_model_inst.mem[1024 + i]);
    chk("auto ctl", udc_mem_model_inst.mem[cw(3, 0) + 2], fin(mk_ctl(3'h2, 10'h004, 4'h1)));
    chk("auto src ptr", udc_mem_model_inst.mem[cw(3, 0)], 32'h0000_100C);
    axi_rd(32'h0000_0004);
    chk("auto enable", rd & 32'h0000_0008, 32'h0000_0000);
    $display("test auto done");
    setup(4, 0, 32'h0000_1008, 32'h0000_1908, mk_ctl(3'h1, 10'h003, 4'h2));
    for (i = 0; i < 3; i++)
      udc_mem_model_inst.mem[1600 + i] = 32'h0000_0000;
    axi_wr(32'h0000_0004, 32'h0000_0010);
    axi_wr(32'h0000_0020, 32'h0000_0010);
    for (i = 0; i < 500 && udc_mem_model_inst.mem[cw(4, 0) + 2] !== mk_ctl(3'h1, 10'h002, 4'h2); i++)
      @(posedge aclk);
    chk("basic one ctl", udc_mem_model_inst.mem[cw(4, 0) + 2], mk_ctl(3'h1, 10'h002, 4'h2));
    chk("basic one item", udc_mem_model_inst.mem[1601], 32'h0000_0000);
    // burst request: both remaining items in one grant
    breq[4] <= 1'b1;
    wait_done(4);
    breq[4] <= 1'b0;
    chk("basic last", udc_mem_model_inst.mem[1602], udc_mem_model_inst.mem[1026]);
    chk("basic ctl", udc_mem_model_inst.mem[cw(4, 0) + 2], fin(mk_ctl(3'h1, 10'h003, 4'h2)));
    $display("test basic done");
    setup(6, 0, 32'h0000_1000, 32'h0000_1A00, mk_ctl(3'h0, 10'h001, 4'h0));
    udc_mem_model_inst.mem[1664] = 32'h5A5A_5A5A;
    axi_wr(32'h0000_0004, 32'h0000_0040);
    axi_wr(32'h0000_0020, 32'h0000_0040);
    for (i = 0; i < 40 && rd[6] !== 1'b0 || i == 0; i++)
      axi_rd(32'h0000_0004);
    chk("stop enable", rd & 32'h0000_0040, 32'h0000_0000);
    chk("stop item", udc_mem_model_inst.mem[1664], 32'h5A5A_5A5A);
    $display("test stop done");
    slow <= 1'b1;
    setup(5, 0, 32'h0000_1000, 32'h0000_1C00, mk_ctl(3'h3, 10'h001, 4'h0));
    setup(5, 1, 32'h0000_1004, 32'h0000_1C04, mk_ctl(3'h3, 10'h001, 4'h0));
    sreq[5] <= 1'b1;
    axi_wr(32'h0000_0004, 32'h0000_0020);
    wait_done(5);
    axi_rd(32'h0000_001C);
    chk("pingpong alt", rd & 32'h0000_0020, 32'h0000_0020);
    wait_done(5);
    sreq[5] <= 1'b0;
    chk("ping item", udc_mem_model_inst.mem[1792], udc_mem_model_inst.mem[1024]);
    chk("pong item", udc_mem_model_inst.mem[1793], udc_mem_model_inst.mem[1025]);
    axi_wr(32'h0000_0008, 32'h0000_0020);
    axi_rd(32'h0000_0004);
    chk("enable clear", rd, 32'h0000_0000);
    chk("table touches", bad, 32'h0000_0000);
    $display("test pingpong done");
    // list entries sit past the table, laid out like structures
    setup(416, 0, 32'h0000_1000, 32'h0000_1D00, mk_ctl(3'h5, 10'h001, 4'h0));
    setup(417, 0, 32'h0000_1004, 32'h0000_1D04, mk_ctl(3'h1, 10'h001, 4'h0));
    setup(7, 0, 32'h0000_1E1C, TB + 32'h0000_027C, mk_ctl(3'h4, 10'h008, 4'h2));
    axi_wr(32'h0000_0004, 32'h0000_0080);
    axi_wr(32'h0000_0020, 32'h0000_0080);
    wait_done(7);
    chk("list item a", udc_mem_model_inst.mem[1856], udc_mem_model_inst.mem[1024]);
    chk("list item b", udc_mem_model_inst.mem[1857], udc_mem_model_inst.mem[1025]);
    chk("list last ctl", udc_mem_model_inst.mem[cw(7, 1) + 2], 32'hAA00_0000);
    chk("list head ctl", udc_mem_model_inst.mem[cw(7, 0) + 2], 32'hAA00_8000);
    $display("test list done");
    print_verdict();
  end
endmodule // tb_top

//--- bench/udc_mem_model.sv
`timescale 1ns/1ps
module udc_mem_model #(
  parameter logic [31:0] TBASE = 32'h0000_0400
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  slow,
  input  wire udc_pkg::udc_mem_req_s mem_req,
  output logic                       mem_ack,
  output logic [31:0]                mem_rdata,
  output logic [31:0]                bad_cnt
);
  logic [31:0] mem [0:4095];
  logic [1:0]  wait_q;
  logic        in_tbl;
  logic [11:0] wi;
  // table sits on a 1024-byte boundary
  assign in_tbl = (mem_req.addr & 32'hFFFF_FC00) == TBASE;
  assign wi     = mem_req.addr[13:2];
  // plain always: the bench preloads mem through hierarchy
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_ack   <= 1'b0;
      wait_q    <= 2'h0;
      bad_cnt   <= 32'h0000_0000;
      mem_rdata <= 32'h0000_0000;
    end
    else
    begin
      mem_ack   <= 1'b0;
      // released data line: no stale value to lean on
      mem_rdata <= ~mem_rdata;
      if (mem_req.valid && !mem_ack)
      begin
        if (slow && wait_q != 2'h3)
          wait_q <= wait_q + 2'h1;
        else
        begin
          wait_q  <= 2'h0;
          mem_ack <= 1'b1;
          if (mem_req.we)
            mem[wi] <= mem_req.wdata;
          else
            mem_rdata <= mem[wi];
          if (in_tbl && (mem_req.addr[3:2] == 2'h3 || (mem_req.we && !mem_req.addr[3])))
            bad_cnt <= bad_cnt + 32'h0000_0001;
        end
      end
    end
  end
endmodule // udc_mem_model

//--- src/udc_arb.sv
`timescale 1ns/1ps
module udc_arb (
  input  wire logic [31:0] req,
  input  wire logic [31:0] prio,
  output logic             any,
  output logic [4:0]       idx
);
  function automatic logic [4:0] first_set(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = i[4:0];
      end
    end
    first_set = r;
  endfunction

  logic [31:0] hi;

  // high priority beats default, lowest number breaks ties
  always_comb
  begin
    hi  = req & prio;
    any = |req;
    idx = (|hi) ? first_set(hi) : first_set(req); // RQ23
  end
endmodule // udc_arb

//--- src/udc_consts.svh
`ifndef UDC_CONSTS_SVH
`define UDC_CONSTS_SVH
// Contract
// RQ1: table is contiguous, base 1024-byte aligned
// RQ2: primary at n*0x10, alternate at 0x200+n*0x10
// RQ3: read src 0x0, dst 0x4, control 0x8
// RQ4: end pointers inclusive; fixed side uses pointer
// RQ5: decode sizes, increments, arbitration, count, burst, mode (code never decodes the burst bit)
// RQ6: write back remaining count and mode
// RQ7: never write either end pointer word
// RQ8: enable set/clear; only enabled channels served
// RQ9: finished transfer clears channel enable
// RQ10: stop mode moves nothing, disables channel
// RQ11: basic mode moves only while requested
// RQ12: momentary request in basic moves one item
// RQ13: basic finish rewrites mode to stop
// RQ14: auto runs to completion, then stop
// RQ15: ping-pong alternates primary and alternate forever
// RQ16: ping-pong signals completion at each switch
// RQ17: scatter-gather primary copies entry into alternate
// RQ18: last entry basic; engine stops after it
// RQ19: scatter-gather signals completion only at end
// RQ20: list writes land in memory for later use
// RQ21: one request drives up to 256 entries
// RQ22: touch no unneeded table words
// RQ23: high priority first, then lowest channel
// RQ24: rearbitrate after arbitration count of items
// RQ25: table base register plus structure offsets
`define UDC_NCH      32
`define UDC_ALT_BIT  9
`define UDC_SRC_OFS  32'h0000_0000
`define UDC_DST_OFS  32'h0000_0004
`define UDC_CTL_OFS  32'h0000_0008
`define UDC_F_MODE   2:0
`define UDC_F_CNT    13:4
`define UDC_F_ARB    17:14
`define UDC_F_SSZ    25:24
`define UDC_F_SINC   27:26
`define UDC_F_DSZ    29:28
`define UDC_F_DINC   31:30
`define UDC_INC_NONE 2'h3
`define UDC_ARB_MAX  4'hA
`define UDC_SZ_WORD  2'h2
`define UDC_R_BASE   8'h00
`define UDC_R_ENSET  8'h04
`define UDC_R_ENCLR  8'h08
`define UDC_R_PRSET  8'h0C
`define UDC_R_PRCLR  8'h10
`define UDC_R_UBSET  8'h14
`define UDC_R_UBCLR  8'h18
`define UDC_R_ALT    8'h1C
`define UDC_R_SWREQ  8'h20
`define UDC_OKAY     2'h0
`define UDC_SLVERR   2'h2
`endif

//--- src/udc_dma.sv
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "udc_consts.svh"
module udc_dma (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [31:0]           s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  input  wire logic [31:0]           dma_sreq,
  input  wire logic [31:0]           dma_breq,
  output udc_pkg::udc_mem_req_s      mem_req,
  input  wire logic                  mem_ack,
  input  wire logic [31:0]           mem_rdata,
  output logic [31:0]                dma_done
);
  udc_pkg::udc_st_s st_ff;
  udc_pkg::udc_st_s nxt_st;
  logic [31:0]      rq;
  logic             gnt_any;
  logic [4:0]       gnt;

  function automatic logic [31:0] st_addr(input logic [21:0] b, input logic a,
                                          input logic [4:0] c, input logic [31:0] o);
    st_addr = {b, 10'h000} + {22'h00_0000, a, c, 4'h0} + o; // RQ2 RQ25
  endfunction

  // inclusive end pointer; fixed side uses it as is
  function automatic logic [31:0] item_addr(input logic [31:0] e, input logic [10:0] r,
                                            input logic [1:0] inc);
    logic [31:0] ofs;
    ofs = ({21'h0_0000, r} - 32'h0000_0001) << inc;
    item_addr = (inc == `UDC_INC_NONE) ? e : e - ofs; // RQ4
  endfunction

  function automatic logic [10:0] arb_len(input logic [3:0] f);
    arb_len = (f >= `UDC_ARB_MAX) ? 11'h400 : (11'h001 << f);
  endfunction

  function automatic udc_pkg::udc_mem_req_s mk_req(input logic w, input logic [1:0] s,
                                                   input logic [31:0] a,
                                                   input logic [31:0] d);
    mk_req = '{valid: 1'b1, we: w, size: s, addr: a, wdata: d};
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic reg_ok(input logic [7:0] a);
    reg_ok = (a[1:0] == 2'h0) && (a <= `UDC_R_SWREQ);
  endfunction

  // single requests ignored where burst-only is set
  assign rq = st_ff.en & (st_ff.sticky | st_ff.swreq | dma_breq | (dma_sreq & ~st_ff.ub)); // RQ8

  udc_arb u_arb (
    .req  (rq),
    .prio (st_ff.prio),
    .any  (gnt_any),
    .idx  (gnt)
  );

  always_comb
  begin
    udc_pkg::udc_mode_e m;
    logic [31:0]        c;
    logic               longrun;
    logic [10:0]        r1;
    logic [31:0]        wc;
    m       = udc_pkg::udc_mode_e'(st_ff.ctl[`UDC_F_MODE]);
    c       = mem_rdata;
    longrun = 1'b0;
    r1      = st_ff.rem - 11'h001;
    wc      = st_ff.ctl;
    nxt_st      = st_ff;
    nxt_st.done = 32'h0000_0000;
    unique case (st_ff.state)
      udc_pkg::UDC_S_IDLE:
      begin
        if (gnt_any)
        begin
          nxt_st.ch         = gnt;
          nxt_st.alt        = st_ff.altsel[gnt]; // RQ22
          nxt_st.multi      = st_ff.sticky[gnt] | dma_breq[gnt];
          nxt_st.swreq[gnt] = 1'b0;
          nxt_st.mreq       = mk_req(1'b0, `UDC_SZ_WORD,
                                     st_addr(st_ff.base, st_ff.altsel[gnt], gnt, `UDC_CTL_OFS),
                                     32'h0000_0000); // RQ3
          nxt_st.state      = udc_pkg::UDC_S_RDCTL;
        end
      end
      udc_pkg::UDC_S_RDCTL:
      begin
        if (mem_ack)
        begin
          nxt_st.ctl = c; // RQ5
          m          = udc_pkg::udc_mode_e'(c[`UDC_F_MODE]);
          if (c[`UDC_F_MODE] == 3'b000 || c[`UDC_F_MODE] > 3'b101)
          begin
            nxt_st.en[st_ff.ch]     = 1'b0; // RQ10
            nxt_st.sticky[st_ff.ch] = 1'b0;
            nxt_st.mreq.valid       = 1'b0;
            nxt_st.state            = udc_pkg::UDC_S_IDLE;
          end
          else
          begin
            // auto and list modes keep requesting once seen
            longrun = st_ff.multi || m == udc_pkg::UDC_M_AUTO || m == udc_pkg::UDC_M_MSG
                      || m == udc_pkg::UDC_M_MSGA; // RQ14 RQ21
            if (m == udc_pkg::UDC_M_AUTO || m == udc_pkg::UDC_M_MSG || m == udc_pkg::UDC_M_MSGA)
            begin
              nxt_st.sticky[st_ff.ch] = 1'b1; // RQ14
            end
            nxt_st.rem   = {1'b0, c[`UDC_F_CNT]} + 11'h001;
            nxt_st.burst = 11'h001; // RQ11 RQ12
            if (longrun)
            begin
              nxt_st.burst = (arb_len(c[`UDC_F_ARB]) < nxt_st.rem) ? arb_len(c[`UDC_F_ARB])
                                                                   : nxt_st.rem; // RQ24
            end
            nxt_st.mreq  = mk_req(1'b0, `UDC_SZ_WORD,
                                  st_addr(st_ff.base, st_ff.alt, st_ff.ch, `UDC_SRC_OFS),
                                  32'h0000_0000); // RQ3
            nxt_st.state = udc_pkg::UDC_S_RDSRC;
          end
        end
      end
      udc_pkg::UDC_S_RDSRC:
      begin
        if (mem_ack)
        begin
          nxt_st.src   = c;
          nxt_st.mreq  = mk_req(1'b0, `UDC_SZ_WORD,
                                st_addr(st_ff.base, st_ff.alt, st_ff.ch, `UDC_DST_OFS),
                                32'h0000_0000); // RQ3
          nxt_st.state = udc_pkg::UDC_S_RDDST;
        end
      end
      udc_pkg::UDC_S_RDDST:
      begin
        if (mem_ack)
        begin
          nxt_st.dst   = c;
          nxt_st.mreq  = mk_req(1'b0, st_ff.ctl[`UDC_F_SSZ],
                                item_addr(st_ff.src, st_ff.rem, st_ff.ctl[`UDC_F_SINC]),
                                32'h0000_0000);
          nxt_st.state = udc_pkg::UDC_S_RDDAT;
        end
      end
      udc_pkg::UDC_S_RDDAT:
      begin
        if (mem_ack)
        begin
          // data words go wherever the entry points, table included;
          // a list copy wraps onto the four alternate words per entry
          nxt_st.mreq  = mk_req(1'b1, st_ff.ctl[`UDC_F_DSZ],
                                item_addr(st_ff.dst, (m == udc_pkg::UDC_M_MSG)
                                          ? ((st_ff.rem - 11'h001) & 11'h003) + 11'h001
                                          : st_ff.rem, st_ff.ctl[`UDC_F_DINC]),
                                c); // RQ17 RQ20
          nxt_st.state = udc_pkg::UDC_S_WRDAT;
        end
      end
      udc_pkg::UDC_S_WRDAT:
      begin
        if (mem_ack)
        begin
          nxt_st.rem   = r1;
          nxt_st.burst = st_ff.burst - 11'h001;
          if (st_ff.burst == 11'h001 || r1 == 11'h000)
          begin
            wc[`UDC_F_CNT] = (r1 == 11'h000) ? 10'h000 : 10'(r1 - 11'h001); // RQ6
            if (r1 == 11'h000)
            begin
              wc[`UDC_F_MODE] = udc_pkg::UDC_M_STOP; // RQ13 RQ14
            end
            // only the control word is ever written back
            nxt_st.mreq  = mk_req(1'b1, `UDC_SZ_WORD,
                                  st_addr(st_ff.base, st_ff.alt, st_ff.ch, `UDC_CTL_OFS),
                                  wc); // RQ7
            nxt_st.state = udc_pkg::UDC_S_WRCTL;
          end
          else
          begin
            nxt_st.mreq  = mk_req(1'b0, st_ff.ctl[`UDC_F_SSZ],
                                  item_addr(st_ff.src, r1, st_ff.ctl[`UDC_F_SINC]),
                                  32'h0000_0000);
            nxt_st.state = udc_pkg::UDC_S_RDDAT;
          end
        end
      end
      udc_pkg::UDC_S_WRCTL:
      begin
        if (mem_ack)
        begin
          nxt_st.mreq.valid = 1'b0;
          nxt_st.state      = udc_pkg::UDC_S_IDLE; // RQ24
          if (m == udc_pkg::UDC_M_MSG && !st_ff.alt)
          begin
            nxt_st.altsel[st_ff.ch] = 1'b1; // RQ17
          end
          else if (st_ff.rem == 11'h000)
          begin
            if (m == udc_pkg::UDC_M_PING)
            begin
              nxt_st.altsel[st_ff.ch] = !st_ff.alt; // RQ15
              nxt_st.done[st_ff.ch]   = 1'b1; // RQ16
            end
            else if (m == udc_pkg::UDC_M_MSGA)
            begin
              nxt_st.altsel[st_ff.ch] = 1'b0; // RQ19
            end
            else
            begin
              nxt_st.en[st_ff.ch]     = 1'b0; // RQ9 RQ18
              nxt_st.sticky[st_ff.ch] = 1'b0;
              nxt_st.altsel[st_ff.ch] = 1'b0;
              nxt_st.done[st_ff.ch]   = 1'b1;
            end
          end
        end
      end
      default:
      begin
        nxt_st.state = udc_pkg::UDC_S_IDLE;
      end
    endcase
    // register slave; software writes come last so they beat the engine's update in the same cycle
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_st.w_got = 1'b1;
      nxt_st.wd    = s_axi_wdata & strb_mask(s_axi_wstrb);
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
    begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = reg_ok(st_ff.aw_addr) ? `UDC_OKAY : `UDC_SLVERR;
      case (st_ff.aw_addr)
        `UDC_R_BASE:  nxt_st.base   = st_ff.wd[31:10]; // RQ25
        `UDC_R_ENCLR:
        begin
          nxt_st.en     = nxt_st.en & ~st_ff.wd; // RQ8
          nxt_st.sticky = nxt_st.sticky & ~st_ff.wd;
        end
        `UDC_R_ENSET: nxt_st.en     = nxt_st.en | st_ff.wd; // RQ8
        `UDC_R_PRSET: nxt_st.prio   = st_ff.prio | st_ff.wd;
        `UDC_R_PRCLR: nxt_st.prio   = st_ff.prio & ~st_ff.wd;
        `UDC_R_UBSET: nxt_st.ub     = st_ff.ub | st_ff.wd;
        `UDC_R_UBCLR: nxt_st.ub     = st_ff.ub & ~st_ff.wd;
        `UDC_R_SWREQ: nxt_st.swreq  = nxt_st.swreq | st_ff.wd;
        default:      nxt_st.bresp  = reg_ok(st_ff.aw_addr) ? `UDC_OKAY : `UDC_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = reg_ok(s_axi_araddr[7:0]) ? `UDC_OKAY : `UDC_SLVERR;
      case (s_axi_araddr[7:0])
        `UDC_R_BASE:  nxt_st.rdata = {st_ff.base, 10'h000};
        `UDC_R_ENSET: nxt_st.rdata = st_ff.en;
        `UDC_R_ENCLR: nxt_st.rdata = st_ff.en;
        `UDC_R_PRSET: nxt_st.rdata = st_ff.prio;
        `UDC_R_PRCLR: nxt_st.rdata = st_ff.prio;
        `UDC_R_UBSET: nxt_st.rdata = st_ff.ub;
        `UDC_R_UBCLR: nxt_st.rdata = st_ff.ub;
        `UDC_R_ALT:   nxt_st.rdata = st_ff.altsel;
        default:      nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign mem_req       = st_ff.mreq;
  assign dma_done      = st_ff.done;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ctl_addr: assert property ((st_ff.state == udc_pkg::UDC_S_RDCTL && st_ff.mreq.valid) |->
    st_ff.mreq.addr == ({st_ff.base, 10'h000} + 32'(st_ff.alt) * 32'h0000_0200
                        + 32'(st_ff.ch) * 32'h0000_0010 + 32'h0000_0008)) // RQ2
    else $error("control word fetched from wrong table slot");
  a_ptr_fetch: assert property ((st_ff.state == udc_pkg::UDC_S_RDDST && st_ff.mreq.valid) |->
    st_ff.mreq.addr[3:0] == 4'h4 && !st_ff.mreq.we) // RQ3
    else $error("destination pointer fetch malformed");
  a_ptr_nowrite: assert property ((st_ff.state == udc_pkg::UDC_S_WRCTL && st_ff.mreq.valid) |->
    st_ff.mreq.addr[3:0] == 4'h8) // RQ7
    else $error("table write outside control word");
  a_final_word: assert property ((st_ff.state == udc_pkg::UDC_S_WRCTL && st_ff.rem == 11'h000)
    |-> st_ff.mreq.wdata[13:0] == 14'h0000) // RQ6
    else $error("finished control word not zero count and stop");
  a_stop_disable: assert property ((st_ff.state == udc_pkg::UDC_S_RDCTL && mem_ack
    && mem_rdata[2:0] == 3'b000 && !(st_ff.aw_got && st_ff.w_got))
    |=> !st_ff.en[$past(st_ff.ch)]) // RQ10
    else $error("stop mode left channel enabled");
  a_grant_en: assert property ((st_ff.state == udc_pkg::UDC_S_IDLE && gnt_any) |->
    st_ff.en[gnt]) // RQ8
    else $error("disabled channel granted");
  a_single_one: assert property ((st_ff.state == udc_pkg::UDC_S_RDCTL && mem_ack
    && !st_ff.multi && mem_rdata[2:0] == 3'b001) |=> st_ff.burst == 11'h001) // RQ12
    else $error("momentary basic request moved more than one item");
  a_burst_cap: assert property ((st_ff.state == udc_pkg::UDC_S_RDSRC) |->
    st_ff.burst != 11'h000 && st_ff.burst <= st_ff.rem
    && st_ff.burst <= arb_len(st_ff.ctl[`UDC_F_ARB])) // RQ24
    else $error("burst exceeds arbitration count or remaining");
  a_pp_switch: assert property ((st_ff.state == udc_pkg::UDC_S_WRCTL && mem_ack
    && st_ff.rem == 11'h000 && st_ff.ctl[2:0] == 3'b011)
    |=> st_ff.altsel[$past(st_ff.ch)] != $past(st_ff.alt) && st_ff.done[$past(st_ff.ch)])
    // RQ15 RQ16
    else $error("ping-pong did not switch and signal");
  a_sg_quiet: assert property ((st_ff.state == udc_pkg::UDC_S_WRCTL && mem_ack
    && st_ff.ctl[2:0] == 3'b101) |=> st_ff.done == 32'h0000_0000) // RQ19
    else $error("list entry signalled completion");

  c_pingpong: cover property (st_ff.state == udc_pkg::UDC_S_WRCTL && mem_ack
    && st_ff.ctl[2:0] == 3'b011 && st_ff.rem == 11'h000);
  c_sg_entry: cover property (st_ff.state == udc_pkg::UDC_S_WRCTL && mem_ack
    && st_ff.ctl[2:0] == 3'b101 && st_ff.rem == 11'h000);
  c_basic_done: cover property (|st_ff.done && !(|(st_ff.done & st_ff.en)));
endmodule // udc_dma

//--- src/udc_pkg.sv
package udc_pkg;
  typedef enum logic [2:0] {
    UDC_M_STOP  = 3'b000,
    UDC_M_BASIC = 3'b001,
    UDC_M_AUTO  = 3'b010,
    UDC_M_PING  = 3'b011,
    UDC_M_MSG   = 3'b100,
    UDC_M_MSGA  = 3'b101
  } udc_mode_e;

  typedef enum logic [2:0] {
    UDC_S_IDLE  = 3'b000,
    UDC_S_RDCTL = 3'b001,
    UDC_S_RDSRC = 3'b010,
    UDC_S_RDDST = 3'b011,
    UDC_S_RDDAT = 3'b100,
    UDC_S_WRDAT = 3'b101,
    UDC_S_WRCTL = 3'b110
  } udc_state_e;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } udc_mem_req_s;

  typedef struct packed {
    udc_state_e   state;
    logic [4:0]   ch;
    logic         alt;
    logic         multi;
    logic [31:0]  ctl;
    logic [31:0]  src;
    logic [31:0]  dst;
    logic [10:0]  rem;
    logic [10:0]  burst;
    udc_mem_req_s mreq;
    logic [31:0]  en;
    logic [31:0]  prio;
    logic [31:0]  ub;
    logic [31:0]  altsel;
    logic [31:0]  sticky;
    logic [31:0]  swreq;
    logic [31:0]  done;
    logic [21:0]  base;
    logic         aw_got;
    logic [7:0]   aw_addr;
    logic         w_got;
    logic [31:0]  wd;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } udc_st_s;
endpackage
